// ---- hdl/groc_params.svh ----
/*
 * Constants of the gas reading output conditioner: scaling, limits and timing.
 * Assumes a 20 MHz core clock and readings scaled so 0x1000 is full scale.
 */
`ifndef GROC_PARAMS_SVH
`define GROC_PARAMS_SVH

// ------------------------------------------------------------
// Clock and timing
// ------------------------------------------------------------
`define GROC_CLK_HZ        20000000
`define GROC_WARMUP_S      15
`define GROC_CAL_ZERO_MS   1000
`define GROC_CAL_SPAN_MS   3000
`define GROC_BAUD          38400

// ------------------------------------------------------------
// Reading scale, full_scale_value = 100 %
// ------------------------------------------------------------
`define GROC_FULL_SCALE    16'sh1000
`define GROC_NEG_FULL      16'shF000
`define GROC_CLAMP_MAX     16'sh2000
`define GROC_SCALE_SHIFT   12
`define GROC_DAC_MAX       12'hFFF
`define GROC_DAC_FAULT     12'h000

// ------------------------------------------------------------
// Supply window in millivolts
// ------------------------------------------------------------
`define GROC_SUPPLY_MIN    13'h0BB8
`define GROC_SUPPLY_MAX    13'h1388

// ------------------------------------------------------------
// Serial frame
// ------------------------------------------------------------
`define GROC_DATA_BITS     4'h8
`define GROC_LAST_BIT      3'h7

`endif

// ---- hdl/groc_pkg.sv ----
/*
 * Types shared by the output conditioner and its serial transmitter.
 * Assumes groc_params.svh is on the include path.
 */
`default_nettype none

package groc_pkg;
    typedef enum logic [1:0] {
        GROC_ST_WARMUP = 2'b00,
        GROC_ST_RUN    = 2'b01,
        GROC_ST_FAULT  = 2'b10
    } groc_state_e;

    typedef enum logic [1:0] {
        GROC_TX_IDLE  = 2'b00,
        GROC_TX_START = 2'b01,
        GROC_TX_DATA  = 2'b10,
        GROC_TX_STOP  = 2'b11
    } groc_tx_state_e;

    typedef logic signed [15:0] groc_reading_t;
endpackage : groc_pkg

`default_nettype wire

// ---- hdl/groc_uart_tx.sv ----
/*
 * Serial byte transmitter: start bit, 8 data bits LSB first, no parity, 1 stop.
 * Assumes one clock and a synchronised active-low reset from the parent.
 */
`include "groc_params.svh"
`default_nettype none

module groc_uart_tx #(
    parameter int unsigned DIV = `GROC_CLK_HZ / `GROC_BAUD
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Byte stream
    input  wire logic [7:0] data,
    input  wire logic       valid,
    output logic            ready,
    // Line
    output logic            tx
);
    import groc_pkg::*;

    groc_tx_state_e state_q;
    logic [15:0]    div_q;
    logic           baud_en;
    logic [2:0]     bit_q;
    logic [7:0]     shift_q;

    assign baud_en = (div_q == 16'(DIV - 1));
    assign ready   = (state_q == GROC_TX_IDLE);

    // Divider restarts with each frame so the start bit has full length.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= 16'h0000;
        end else if (ready || baud_en) begin
            div_q <= 16'h0000;
        end else begin
            div_q <= div_q + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= GROC_TX_IDLE;
            bit_q   <= 3'h0;
            shift_q <= 8'h00;
            tx      <= 1'b1;
        end else begin
            case (state_q)
                GROC_TX_IDLE: begin
                    if (valid) begin // R15
                        shift_q <= data;
                        tx      <= 1'b0;
                        state_q <= GROC_TX_START;
                    end
                end
                GROC_TX_START: begin
                    if (baud_en) begin
                        tx      <= shift_q[0];
                        bit_q   <= 3'h0;
                        state_q <= GROC_TX_DATA;
                    end
                end
                GROC_TX_DATA: begin
                    if (baud_en) begin
                        if (bit_q == `GROC_LAST_BIT) begin
                            tx      <= 1'b1;
                            state_q <= GROC_TX_STOP;
                        end else begin
                            tx      <= shift_q[bit_q + 3'h1];
                            bit_q   <= bit_q + 3'h1;
                        end
                    end
                end
                GROC_TX_STOP: begin
                    if (baud_en) begin
                        state_q <= GROC_TX_IDLE;
                    end
                end
                default: begin
                    state_q <= GROC_TX_IDLE;
                    tx      <= 1'b1;
                end
            endcase
        end
    end
endmodule : groc_uart_tx

`default_nettype wire

// ---- hdl/groc_top.sv ----
/*
 * Gas reading output conditioner: picks the value reported on the voltage
 * output code and over the serial line, handles warm-up, freeze, clamp,
 * fault forcing and manual calibration by grounding the receive pin.
 * Assumes the measurement path and self-check logic share CORE_CLK; the
 * receive pin is asynchronous and synchronised here.
 */
// What this block does
// R1: Hold start-up output level after power-on.
// R2: Warm-up lasts 15 s, then follow gas.
// R3: Serial reading is zero during warm-up.
// R4: Warm-up level and duration are configurable.
// R5: Freeze output during thermal or flow transients.
// R6: Clamp reading at 200 percent full scale.
// R7: Host decides and indicates over-range itself.
// R8: Continuously check memory, supply, analogue values.
// R9: Fault forces output to minus full scale.
// R10: Scaled voltage output goes to zero on fault.
// R11: Serial reading is minus full scale on fault.
// R12: Supply outside 3 to 5 V is fault.
// R13: Grounded serial pin triggers zero or span.
// R14: Host avoids 0 V as zero-gas level.
// R15: Serial frames: 8 data, no parity, 1 stop.
// R16: Serial rate 38400 baud unless configured.
// R17: Fault beats freeze and clamp after warm-up.
// R18: Warm-up timed by clock counter from reset.
`include "groc_params.svh"
`default_nettype none

module groc_top #(
    parameter int unsigned WARMUP_CYCLES = `GROC_WARMUP_S * `GROC_CLK_HZ,
    parameter int unsigned CAL_ZERO_CYCLES = `GROC_CAL_ZERO_MS * (`GROC_CLK_HZ / 1000),
    parameter int unsigned CAL_SPAN_CYCLES = `GROC_CAL_SPAN_MS * (`GROC_CLK_HZ / 1000),
    parameter int unsigned BAUD_RATE = `GROC_BAUD
) (
    // Clock and reset
    input  wire logic                   CORE_CLK,
    input  wire logic                   RESETN,
    // Measurement path
    input  wire groc_pkg::groc_reading_t MEAS_READING,
    input  wire logic                   MEAS_VALID,
    input  wire logic                   TRANSIENT,
    // Self-check results
    input  wire logic                   MEM_CHECK_OK,
    input  wire logic                   ANALOG_CHECK_OK,
    input  wire logic [12:0]            SUPPLY_MV,
    // Configuration
    input  wire logic [11:0]            ZERO_CODE,
    input  wire logic [11:0]            SPAN_CODE,
    input  wire logic [11:0]            WARMUP_CODE,
    input  wire logic                   WARMUP_CUSTOM,
    // Outputs
    output groc_pkg::groc_reading_t     READING,
    output logic [11:0]                 DAC_CODE,
    output logic                        WARMUP_ACTIVE,
    output logic                        FAULT,
    // Calibration
    output logic                        CAL_ZERO,
    output logic                        CAL_SPAN,
    // Serial pins
    input  wire logic                   RX_PIN,
    output logic                        TX_PIN
);
    import groc_pkg::*;

    // ------------------------------------------------------------
    // Reset release and pin synchroniser
    // ------------------------------------------------------------
    logic rst_s1_q, rst_n;
    logic rx_s1_q, rx_s2_q;

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
        end else begin
            rx_s1_q <= RX_PIN;
            rx_s2_q <= rx_s1_q;
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic groc_reading_t clamp_reading(input logic signed [16:0] v);
        if (v > 17'(`GROC_CLAMP_MAX)) begin
            clamp_reading = `GROC_CLAMP_MAX;
        end else if (v < 17'(`GROC_NEG_FULL)) begin
            clamp_reading = `GROC_NEG_FULL;
        end else begin
            clamp_reading = v[15:0];
        end
    endfunction : clamp_reading

    // Maps a reading linearly from zero code (reading 0) to span code (full scale), clamped to the DAC code range.
    function automatic logic [11:0] to_dac(input groc_reading_t rd,
                                           input logic [11:0] zc,
                                           input logic [11:0] sc);
        logic signed [31:0] delta;
        logic signed [31:0] v;
        delta = 32'(signed'({1'b0, sc})) - 32'(signed'({1'b0, zc}));
        v = ((32'(rd) * delta) >>> `GROC_SCALE_SHIFT) + 32'(signed'({1'b0, zc}));
        if (v < 0) begin
            to_dac = 12'h000;
        end else if (v > 32'(`GROC_DAC_MAX)) begin
            to_dac = `GROC_DAC_MAX;
        end else begin
            to_dac = v[11:0];
        end
    endfunction : to_dac

    // ------------------------------------------------------------
    // Warm-up timer and mode
    // ------------------------------------------------------------
    groc_state_e state_q;
    logic [31:0] warm_cnt_q;
    logic        fault_now;
    logic        warm_done;

    assign warm_done = (warm_cnt_q >= WARMUP_CYCLES - 1);

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            warm_cnt_q <= 32'h0000_0000;
        end else if (!warm_done) begin
            warm_cnt_q <= warm_cnt_q + 32'h0000_0001; // R18
        end
    end

    // Supply, memory and analogue checks are re-evaluated every cycle.
    assign fault_now = !MEM_CHECK_OK || !ANALOG_CHECK_OK          // R8
                     || (SUPPLY_MV < `GROC_SUPPLY_MIN)
                     || (SUPPLY_MV > `GROC_SUPPLY_MAX);            // R12

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= GROC_ST_WARMUP;
        end else begin
            case (state_q)
                GROC_ST_WARMUP: if (warm_done) state_q <= GROC_ST_RUN; // R2
                GROC_ST_RUN:    if (fault_now) state_q <= GROC_ST_FAULT;
                GROC_ST_FAULT:  if (!fault_now) state_q <= GROC_ST_RUN;
                default:        state_q <= GROC_ST_WARMUP;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Calibration by holding the receive pin low
    // ------------------------------------------------------------
    logic [31:0]   low_cnt_q;
    groc_reading_t zero_off_q;

    // A UART character never keeps the line low this long, so a held low is
    // unambiguous; the release edge decides between zero and span.
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            low_cnt_q <= 32'h0000_0000;
            CAL_ZERO  <= 1'b0;
            CAL_SPAN  <= 1'b0;
        end else begin
            CAL_ZERO <= 1'b0;
            CAL_SPAN <= 1'b0;
            if (!rx_s2_q) begin
                if (low_cnt_q < CAL_SPAN_CYCLES) low_cnt_q <= low_cnt_q + 32'h0000_0001;
            end else begin
                low_cnt_q <= 32'h0000_0000;
                if (low_cnt_q >= CAL_SPAN_CYCLES) begin
                    CAL_SPAN <= 1'b1; // R13
                end else if (low_cnt_q >= CAL_ZERO_CYCLES) begin
                    CAL_ZERO <= 1'b1; // R13
                end
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            zero_off_q <= 16'sh0000;
        end else if (CAL_ZERO) begin
            zero_off_q <= MEAS_READING; // R13
        end
    end

    // ------------------------------------------------------------
    // Reported value selection
    // ------------------------------------------------------------
    groc_reading_t live;
    logic          upd_q;
    logic          accept;

    assign live = clamp_reading(17'(MEAS_READING) - 17'(zero_off_q)); // R6

    // Only an accepted reading starts a serial update, so no frame leaves during warm-up.
    assign accept = MEAS_VALID && !TRANSIENT && (state_q == GROC_ST_RUN) && !fault_now; // R3 R5

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            READING  <= 16'sh0000;
            DAC_CODE <= 12'h000;
            upd_q    <= 1'b0;
        end else begin
            upd_q <= accept;
            if (state_q == GROC_ST_WARMUP) begin
                READING  <= 16'sh0000;                                  // R3
                DAC_CODE <= WARMUP_CUSTOM ? WARMUP_CODE : ZERO_CODE;   // R1 R4
            end else if (state_q == GROC_ST_FAULT || fault_now) begin
                READING  <= `GROC_NEG_FULL;                            // R9 R11 R17
                DAC_CODE <= `GROC_DAC_FAULT;                           // R10
            end else if (MEAS_VALID && !TRANSIENT) begin               // R5
                READING  <= live;
                DAC_CODE <= to_dac(live, ZERO_CODE, SPAN_CODE);
            end
        end
    end

    assign WARMUP_ACTIVE = (state_q == GROC_ST_WARMUP);
    assign FAULT         = (state_q == GROC_ST_FAULT);

    // ------------------------------------------------------------
    // Serial reading: high byte then low byte after each update that arrives with no frame pending and the transmitter idle
    // ------------------------------------------------------------
    logic       tx_ready;
    logic       tx_valid;
    logic [7:0] tx_byte;
    logic       lo_pend_q;
    logic       hi_pend_q;
    logic [7:0] lo_q;

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            hi_pend_q <= 1'b0;
            lo_pend_q <= 1'b0;
            lo_q      <= 8'h00;
        end else if (hi_pend_q && tx_ready) begin
            hi_pend_q <= 1'b0;
            lo_pend_q <= 1'b1;
        end else if (lo_pend_q && tx_ready) begin
            lo_pend_q <= 1'b0;
        end else if (upd_q && !hi_pend_q && !lo_pend_q && tx_ready) begin
            hi_pend_q <= 1'b1;
            lo_q      <= READING[7:0];
        end
    end

    assign tx_valid = hi_pend_q || lo_pend_q;
    assign tx_byte  = hi_pend_q ? READING[15:8] : lo_q;

    groc_uart_tx #(
        .DIV (`GROC_CLK_HZ / BAUD_RATE) // R16
    ) u_tx (
        .clk   (CORE_CLK),
        .rst_n (rst_n),
        .data  (tx_byte),
        .valid (tx_valid),
        .ready (tx_ready),
        .tx    (TX_PIN)
    );
endmodule : groc_top

`default_nettype wire

// ---- dv/groc_top_props.sv ----
/*
 * Port-level checker for the gas reading output conditioner.
 * Assumes it is bound to groc_top, one CORE_CLK domain, RESETN active low.
 */
`include "groc_params.svh"
`default_nettype none

module groc_top_props #(
    parameter int unsigned WARMUP_CYCLES = 50
) (
    // Clock, reset and inputs
    input wire logic                    CORE_CLK,
    input wire logic                    RESETN,
    input wire logic                    TRANSIENT,
    input wire logic                    MEM_CHECK_OK,
    input wire logic                    ANALOG_CHECK_OK,
    input wire logic [12:0]             SUPPLY_MV,
    input wire logic [11:0]             ZERO_CODE,
    input wire logic [11:0]             WARMUP_CODE,
    input wire logic                    WARMUP_CUSTOM,
    input wire logic                    RX_PIN,
    // Outputs
    input wire groc_pkg::groc_reading_t READING,
    input wire logic [11:0]             DAC_CODE,
    input wire logic                    WARMUP_ACTIVE,
    input wire logic                    FAULT,
    input wire logic                    CAL_ZERO,
    input wire logic                    CAL_SPAN,
    input wire logic                    TX_PIN
);
    timeunit 1ns;
    timeprecision 1ns;

    import groc_pkg::*;

    logic [31:0] warm_cnt_q;
    logic        bad_now;

    assign bad_now = !MEM_CHECK_OK || !ANALOG_CHECK_OK || (SUPPLY_MV < `GROC_SUPPLY_MIN)
                     || (SUPPLY_MV > `GROC_SUPPLY_MAX);

    // The count includes the two edges of the reset synchroniser, hence the slack below.
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            warm_cnt_q <= 32'h0;
        end else if (WARMUP_ACTIVE) begin
            warm_cnt_q <= warm_cnt_q + 32'h1;
        end
    end

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);

    warm_hold_a: assert property (WARMUP_ACTIVE |-> READING == 16'sh0000)
        else $error("serial reading not zero during warm-up");
    warm_level_a: assert property ((WARMUP_ACTIVE && warm_cnt_q >= 32'h6) |->
        DAC_CODE == (WARMUP_CUSTOM ? WARMUP_CODE : ZERO_CODE))
        else $error("warm-up output level wrong");
    warm_length_a: assert property ($fell(WARMUP_ACTIVE) |->
        warm_cnt_q >= WARMUP_CYCLES && warm_cnt_q <= WARMUP_CYCLES + 4)
        else $error("warm-up ended at the wrong cycle");
    warm_bound_a: assert property (WARMUP_ACTIVE |-> warm_cnt_q <= WARMUP_CYCLES + 4)
        else $error("warm-up lasts too long");
    fault_entry_a: assert property ((bad_now && !WARMUP_ACTIVE) |-> ##[1:2] FAULT)
        else $error("failed check not flagged as fault");
    fault_exit_a: assert property ((!bad_now)[*3] |-> !FAULT)
        else $error("fault flagged with all checks passing");
    fault_value_a: assert property (FAULT |-> READING == `GROC_NEG_FULL &&
        DAC_CODE == `GROC_DAC_FAULT)
        else $error("fault value not forced on outputs");
    clamp_range_a: assert property (READING <= `GROC_CLAMP_MAX && READING >= `GROC_NEG_FULL)
        else $error("reading outside clamp range");
    freeze_hold_a: assert property ((TRANSIENT && !FAULT)[*4] |->
        $stable(READING) && $stable(DAC_CODE))
        else $error("output moved during transient");
    cal_single_a: assert property (CAL_ZERO |=> !CAL_ZERO && !CAL_SPAN)
        else $error("calibration pulse too long");
    cal_quiet_a: assert property (RX_PIN[*8] |-> !CAL_ZERO)
        else $error("zero calibration without grounded pin");
    tx_quiet_a: assert property (WARMUP_ACTIVE |-> TX_PIN)
        else $error("serial traffic during warm-up");
endmodule : groc_top_props

bind groc_top groc_top_props #(.WARMUP_CYCLES(WARMUP_CYCLES)) i_props (
    .CORE_CLK(CORE_CLK), .RESETN(RESETN), .TRANSIENT(TRANSIENT), .MEM_CHECK_OK(MEM_CHECK_OK),
    .ANALOG_CHECK_OK(ANALOG_CHECK_OK), .SUPPLY_MV(SUPPLY_MV), .ZERO_CODE(ZERO_CODE),
    .WARMUP_CODE(WARMUP_CODE), .WARMUP_CUSTOM(WARMUP_CUSTOM), .RX_PIN(RX_PIN),
    .READING(READING), .DAC_CODE(DAC_CODE), .WARMUP_ACTIVE(WARMUP_ACTIVE), .FAULT(FAULT),
    .CAL_ZERO(CAL_ZERO), .CAL_SPAN(CAL_SPAN), .TX_PIN(TX_PIN)
);

`default_nettype wire

// ---- dv/groc_host_rx.sv ----
/*
 * Host-side serial receiver that decodes the reading frames.
 * Assumes the line idles high and DIV clock cycles per bit.
 */
`default_nettype none

module groc_host_rx #(
    parameter int unsigned DIV = 10
) (
    input  wire logic  clk,
    input  wire logic  line,
    output logic [7:0] data,
    output logic       got,
    output logic       stop_ok
);
    timeunit 1ns;
    timeprecision 1ns;

    // Samples at mid-bit so a wrong bit time shows up as corrupted bytes.
    initial begin
        got = 1'b0;
        data = 8'h00;
        stop_ok = 1'b0;
        forever begin
            @(negedge line);
            repeat (DIV / 2) @(posedge clk);
            if (line === 1'b0) begin
                for (int i = 0; i < 8; i++) begin
                    repeat (DIV) @(posedge clk);
                    data[i] = line;
                end
                repeat (DIV) @(posedge clk);
                stop_ok = line;
                got = 1'b1;
                @(posedge clk);
                got = 1'b0;
            end
        end
    end
endmodule : groc_host_rx

`default_nettype wire

// ---- dv/test_gas_reading_output_conditioner.sv ----
/*
 * Self-checking bench for the gas reading output conditioner.
 * Assumes groc_top, groc_host_rx and the bound checker are compiled before it.
 */
`default_nettype none

module test_gas_reading_output_conditioner import groc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int unsigned WARM = 50;
    logic          clk, rst_n, meas_valid, transient, mem_ok, ana_ok, warm_custom;
    logic          rx_pin, warm_active, fault, cal_zero, cal_span, tx_pin, got, stop_ok;
    logic [12:0]   supply_mv;
    logic [11:0]   zero_code, span_code, warm_code, dac_code, last_d;
    logic [7:0]    rx_byte;
    logic [7:0]    exp_q[$];
    logic [31:0]   seed;
    groc_reading_t meas_reading, reading, offset, last_r;
    int            mismatches, checks_done, k;

    groc_top #(.WARMUP_CYCLES(WARM), .CAL_ZERO_CYCLES(20), .CAL_SPAN_CYCLES(60),
               .BAUD_RATE(2000000)) i_dut (
        .CORE_CLK(clk), .RESETN(rst_n), .MEAS_READING(meas_reading), .MEAS_VALID(meas_valid),
        .TRANSIENT(transient), .MEM_CHECK_OK(mem_ok), .ANALOG_CHECK_OK(ana_ok),
        .SUPPLY_MV(supply_mv), .ZERO_CODE(zero_code), .SPAN_CODE(span_code),
        .WARMUP_CODE(warm_code), .WARMUP_CUSTOM(warm_custom), .READING(reading),
        .DAC_CODE(dac_code), .WARMUP_ACTIVE(warm_active), .FAULT(fault), .CAL_ZERO(cal_zero),
        .CAL_SPAN(cal_span), .RX_PIN(rx_pin), .TX_PIN(tx_pin)
    );
    groc_host_rx #(.DIV(10)) i_host (
        .clk(clk), .line(tx_pin), .data(rx_byte), .got(got), .stop_ok(stop_ok)
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    function automatic groc_reading_t exp_rd(input groc_reading_t v);
        int d;
        d = int'(v) - int'(offset);
        if (d > 32'sh2000) d = 32'sh2000;
        if (d < -32'sh1000) d = -32'sh1000;
        return groc_reading_t'(d);
    endfunction : exp_rd

    function automatic logic [11:0] exp_dac(input groc_reading_t v);
        int d;
        d = int'(zero_code) + ((int'(v) * (int'(span_code) - int'(zero_code))) >>> 12);
        if (d > 32'sh0FFF) d = 32'sh0FFF;
        if (d < 32'sh0) d = 32'sh0;
        return 12'(d);
    endfunction : exp_dac

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // A refused reading must leave both outputs at their previous values.
    task automatic meas(input groc_reading_t v, input bit acc, input int gap);
        last_r = acc ? exp_rd(v) : last_r;
        last_d = acc ? exp_dac(last_r) : last_d;
        @(negedge clk);
        meas_reading = v;
        meas_valid = 1'b1;
        @(negedge clk);
        meas_valid = 1'b0;
        repeat (3) @(negedge clk);
        check("reading", reading, last_r);
        check("dac code", dac_code, last_d);
        if (acc) begin
            exp_q.push_back(last_r[15:8]);
            exp_q.push_back(last_r[7:0]);
        end
        repeat (gap) @(negedge clk);
    endtask : meas

    task automatic wait_on(input int sel, input int lim);
        int n;
        n = 0;
        while (!(sel == 0 ? warm_active === 1'b0 : sel == 1 ? cal_zero === 1'b1
                 : cal_span === 1'b1)) begin
            @(negedge clk);
            n++;
            if (n > lim) begin
                mismatches++;
                tally_and_finish;
            end
        end
    endtask : wait_on

    always @(posedge got) begin
        check("serial byte", rx_byte, exp_q.size() > 0 ? exp_q.pop_front() : 16'h0100);
        check("stop bit", stop_ok, 1'b1);
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        meas_valid = 1'b0;
        transient = 1'b0;
        mem_ok = 1'b1;
        ana_ok = 1'b1;
        supply_mv = 13'h1000;
        meas_reading = 16'sh0000;
        zero_code = 12'h100;
        span_code = 12'h800;
        warm_code = 12'h333;
        warm_custom = 1'b1;
        rx_pin = 1'b1;
        seed = 32'h0000C6A8;
        offset = 16'sh0000;
        last_r = 16'sh0000;
        last_d = 12'h333;
        mismatches = 0;
        checks_done = 0;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        meas(16'sh0800, 1'b0, 0);
        wait_on(0, 100);
        for (k = 0; k < 8; k++) begin
            seed = xs(seed);
            meas(groc_reading_t'({3'h0, seed[12:0]}), 1'b1, 250);
        end
        meas(16'sh3000, 1'b1, 250);
        check("host over-range", reading > 16'sh1000, 1'b1);
        transient = 1'b1;
        meas(16'sh0400, 1'b0, 0);
        transient = 1'b0;
        meas(16'sh0400, 1'b1, 250);
        // Cases 4 and 5 sit exactly on the supply window edges and must not fault.
        for (k = 0; k < 6; k++) begin
            mem_ok = (k != 0);
            ana_ok = (k != 1);
            supply_mv = k == 2 ? 13'h0BB7 : k == 3 ? 13'h1389 : k == 4 ? 13'h0BB8 : 13'h1388;
            transient = 1'b1;
            repeat (4) @(negedge clk);
            check("fault flag", fault, k < 4);
            if (k < 4) begin
                last_r = 16'shF000;
                last_d = 12'h000;
            end
            meas(16'sh3000, 1'b0, 0);
        end
        supply_mv = 13'h1000;
        transient = 1'b0;
        meas(16'sh0200, 1'b1, 250);
        meas_reading = 16'sh0100;
        rx_pin = 1'b0;
        repeat (30) @(negedge clk);
        rx_pin = 1'b1;
        wait_on(1, 20);
        offset = 16'sh0100;
        repeat (4) @(negedge clk);
        meas(16'sh0500, 1'b1, 250);
        rx_pin = 1'b0;
        repeat (70) @(negedge clk);
        rx_pin = 1'b1;
        wait_on(2, 20);
        repeat (10) @(negedge clk);
        warm_custom = 1'b0;
        rst_n = 1'b0;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        repeat (8) @(negedge clk);
        check("default warm level", dac_code, zero_code);
        check("warm reading", reading, 16'h0000);
        check("pending bytes", 16'(exp_q.size()), 16'h0000);
        tally_and_finish;
    end
endmodule : test_gas_reading_output_conditioner

`default_nettype wire
